// File: hdl/ucl_pkg.sv
package ucl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] UCL_OFS_FLASH_CTRL  = 16'h1240;
    localparam logic [15:0] UCL_OFS_FW_VERSION  = 16'h1F60;
    localparam logic [15:0] UCL_OFS_FW_DATE     = 16'h1F64;
    localparam logic [15:0] UCL_OFS_FW_DESC     = 16'h1F68;
    localparam logic [15:0] UCL_OFS_SET_CTRL    = 16'h1300;
    localparam logic [15:0] UCL_OFS_SET_STATUS  = 16'h1304;
    localparam logic [15:0] UCL_OFS_SET_INDEX   = 16'h1308;
    localparam logic [15:0] UCL_OFS_SET_DATA    = 16'h130C;
    localparam logic [15:0] UCL_OFS_ENV         = 16'h1310;
    localparam logic [15:0] UCL_OFS_LIVE_BASE   = 16'h1400;

    // ------------------------------------------------------------
    // Settings sets
    // ------------------------------------------------------------
    localparam int          UCL_NUM_SETS   = 3;
    localparam int          UCL_SET_WORDS  = 16;
    localparam logic [1:0]  UCL_SET_FACTORY = 2'h0;
    localparam logic [1:0]  UCL_SET_LAST    = 2'h2;

    // Field positions of the set control register
    localparam int UCL_CTRL_SEL_LSB   = 0;
    localparam int UCL_CTRL_SAVE_BIT  = 4;
    localparam int UCL_CTRL_LOAD_BIT  = 5;

    // Reset values
    localparam logic [31:0] UCL_RST_FLASH_CTRL = 32'h0000_0000;
    localparam logic [31:0] UCL_RST_WORD       = 32'h0000_0000;

    // Arbitrary neutral identity values
    localparam logic [31:0] UCL_FW_VERSION = 32'h0001_0000;
    localparam logic [31:0] UCL_FW_DATE    = 32'h0000_0001;
    localparam logic [31:0] UCL_FW_DESC    = 32'h5553_4552;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int UCL_CLK_HZ        = 200_000_000;
    localparam int UCL_BLANK_MS      = 100;
    localparam int UCL_BLANK_CYCLES  = UCL_CLK_HZ / 1000 * UCL_BLANK_MS;

    // Loader states, Gray along idle->load->copy->save
    typedef enum logic [1:0] {
        UCL_IDLE = 2'b00,
        UCL_LOAD = 2'b01,
        UCL_COPY = 2'b11,
        UCL_SAVE = 2'b10
    } ucl_state_t;

    // Environmental reading carried together
    typedef struct packed {
        logic [15:0] temp_c;
        logic [15:0] humid_pct;
    } ucl_env_t;

endpackage

// File: hdl/ucl_loader.sv
module ucl_loader
    import ucl_pkg::*;
#(
    parameter int BLANK_CYCLES = UCL_BLANK_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        CE,
    // Avalon-MM slave
    input  wire logic [15:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [1:0]  AVS_RESPONSE,
    // Non-volatile last saved index and reinit request
    input  wire logic [1:0]  NV_LAST_SET,
    output logic      [1:0]  NV_LAST_SET_WR,
    output logic             NV_LAST_SET_WE,
    input  wire logic        REINIT,
    // Environmental sensors
    input  wire ucl_env_t    ENV_IN,
    // Camera side
    output logic             IMAGE_ENABLE,
    output logic             AUTO_RESTART,
    output logic             CFG_VALID,
    output logic      [31:0] FLASH_CTRL
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Counter wide enough to park at the blanking limit
    localparam int CW = $clog2(BLANK_CYCLES + 1);

    logic [31:0] live    [UCL_SET_WORDS];
    logic [31:0] user_set[1:UCL_NUM_SETS-1][UCL_SET_WORDS];
    logic [31:0] factory [UCL_SET_WORDS];
    logic [CW-1:0] blank_cnt;
    logic [1:0]  last_set;
    logic [1:0]  sel_set;
    logic [3:0]  word_idx;
    logic [3:0]  data_idx;
    logic        booted;
    ucl_state_t  state;
    ucl_env_t    env;

    // Factory image is a constant so it cannot be overwritten
    always_comb begin
        for (int i = 0; i < UCL_SET_WORDS; i++) begin
            factory[i] = UCL_RST_WORD;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // A request is taken on the edge where it meets a high waitrequest
    wire        req      = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & CE;
    wire        hit_fctl = (AVS_ADDRESS == UCL_OFS_FLASH_CTRL);
    wire        hit_ver  = (AVS_ADDRESS == UCL_OFS_FW_VERSION);
    wire        hit_date = (AVS_ADDRESS == UCL_OFS_FW_DATE);
    wire        hit_desc = (AVS_ADDRESS == UCL_OFS_FW_DESC);
    wire        hit_sctl = (AVS_ADDRESS == UCL_OFS_SET_CTRL);
    wire        hit_stat = (AVS_ADDRESS == UCL_OFS_SET_STATUS);
    wire        hit_sidx = (AVS_ADDRESS == UCL_OFS_SET_INDEX);
    wire        hit_sdat = (AVS_ADDRESS == UCL_OFS_SET_DATA);
    wire        hit_env  = (AVS_ADDRESS == UCL_OFS_ENV);
    wire        hit_live = (AVS_ADDRESS[15:6] == UCL_OFS_LIVE_BASE[15:6])
                           & (AVS_ADDRESS[1:0] == 2'h0);
    wire [3:0]  live_idx = AVS_ADDRESS[5:2];
    wire        hit_any  = hit_fctl | hit_ver | hit_date | hit_desc | hit_sctl
                           | hit_stat | hit_sidx | hit_sdat | hit_env | hit_live;
    wire        busy     = (state != UCL_IDLE);
    // A write commits only at the edge where the master sees waitrequest low,
    // so a request held through its wait cycle still lands exactly once
    wire        ack      = ~AVS_WAITREQUEST & CE;
    wire        wr       = ack & AVS_WRITE;
    wire [1:0]  wr_sel   = AVS_WRITEDATA[UCL_CTRL_SEL_LSB +: 2];
    wire        sel_ok   = (wr_sel <= UCL_SET_LAST);
    wire        do_save  = wr & hit_sctl & AVS_WRITEDATA[UCL_CTRL_SAVE_BIT] & sel_ok & ~busy;
    wire        do_load  = wr & hit_sctl & AVS_WRITEDATA[UCL_CTRL_LOAD_BIT] & ~busy;
    wire        do_sel   = wr & hit_sctl & sel_ok & ~busy;

    // ------------------------------------------------------------
    // Write strobes and set words
    // ------------------------------------------------------------
    // Register write strobes; each names the one register it may touch
    wire        wr_fctl  = wr & hit_fctl;
    wire        wr_sidx  = wr & hit_sidx & AVS_BYTEENABLE[0];
    // Live words stay untouched while a load or save walks them
    wire        wr_live  = wr & hit_live & ~busy;
    // Reload starts only from idle, so a request during a walk is dropped
    wire        load_go  = (state == UCL_IDLE) & (REINIT | do_load);
    // A stored index of 3 was never a valid save, so boot falls back to factory
    wire [1:0]  boot_set = (NV_LAST_SET <= UCL_SET_LAST) ? NV_LAST_SET : UCL_SET_FACTORY;
    // Set 0 always reads the constant factory image
    wire [31:0] copy_word = (sel_set == UCL_SET_FACTORY) ? factory[word_idx]
                                                          : user_set[sel_set][word_idx];
    wire [31:0] view_word = (sel_set == UCL_SET_FACTORY) ? factory[data_idx]
                                                          : user_set[sel_set][data_idx];
    // Blanking is over once the counter has parked at its limit
    wire        blank_done = (blank_cnt == CW'(BLANK_CYCLES));

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Read mux; an unmapped address reads zero and answers with a decode error
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_fctl) begin
            next_rdata = FLASH_CTRL;
        end else if (hit_ver) begin
            next_rdata = UCL_FW_VERSION;
        end else if (hit_date) begin
            next_rdata = UCL_FW_DATE;
        end else if (hit_desc) begin
            next_rdata = UCL_FW_DESC;
        end else if (hit_sctl) begin
            next_rdata = {30'h0, sel_set};
        end else if (hit_stat) begin
            next_rdata = {26'h0, booted, busy, 2'h0, last_set};
        end else if (hit_sidx) begin
            next_rdata = {28'h0, data_idx};
        end else if (hit_sdat) begin
            next_rdata = view_word;
        end else if (hit_env) begin
            next_rdata = env;
        end else if (hit_live) begin
            next_rdata = live[live_idx];
        end
    end

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, then answer
    // ------------------------------------------------------------
    // Read data are registered with the wait cycle, so they stand at the answer edge
    always_ff @(posedge CLK) begin
        if (SRST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h0000_0000;
            AVS_RESPONSE    <= 2'h0;
        end else if (CE) begin
            AVS_WAITREQUEST <= ~req;
            if (req) begin
                AVS_READDATA <= next_rdata;
                AVS_RESPONSE <= hit_any ? 2'h0 : 2'h3;  // Unmapped gives decode error
            end
        end
    end

    // ------------------------------------------------------------
    // Simple software registers and sensor capture
    // ------------------------------------------------------------
    // Sensors are sampled every enabled cycle; software sees a reading two cycles old at the answer edge
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FLASH_CTRL <= UCL_RST_FLASH_CTRL;
            data_idx   <= 4'h0;
            env        <= '0;
        end else if (CE) begin
            env <= ENV_IN;
            if (wr_fctl) begin
                FLASH_CTRL <= merge(FLASH_CTRL, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
            if (wr_sidx) begin
                data_idx <= AVS_WRITEDATA[3:0];
            end
        end
    end

    // Live settings: frame rate, format, trigger, GPIO, pixel coding...
    always_ff @(posedge CLK) begin
        if (CE) begin
            if (state == UCL_COPY) begin
                live[word_idx] <= copy_word;
            end else if (wr_live) begin
                live[live_idx] <= merge(live[live_idx], AVS_WRITEDATA, AVS_BYTEENABLE);
            end
        end
    end

    // Save path writes the whole live image into a user set only
    always_ff @(posedge CLK) begin
        if (CE && state == UCL_SAVE && sel_set != UCL_SET_FACTORY) begin
            user_set[sel_set][word_idx] <= live[word_idx];
        end
    end

    // ------------------------------------------------------------
    // Loader sequence
    // ------------------------------------------------------------
    // Load walks the set word by word; the camera sees config only when done
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state          <= UCL_LOAD;
            sel_set        <= UCL_SET_FACTORY;
            last_set       <= UCL_SET_FACTORY;
            word_idx       <= 4'h0;
            booted         <= 1'b0;
            CFG_VALID      <= 1'b0;
            AUTO_RESTART   <= 1'b0;
            NV_LAST_SET_WE <= 1'b0;
            NV_LAST_SET_WR <= 2'h0;
        end else if (CE) begin
            NV_LAST_SET_WE <= 1'b0;
            AUTO_RESTART   <= 1'b0;
            case (state)
                UCL_IDLE: begin
                    if (load_go) begin
                        sel_set   <= last_set;
                        state     <= UCL_LOAD;
                        CFG_VALID <= 1'b0;
                    end else if (do_save) begin
                        // Save to set 0 stores nothing; it only points the next boot, the reload and the viewed set at factory
                        sel_set  <= wr_sel;
                        last_set <= wr_sel;
                        NV_LAST_SET_WR <= wr_sel;
                        NV_LAST_SET_WE <= 1'b1;
                        word_idx <= 4'h0;
                        if (wr_sel != UCL_SET_FACTORY) begin
                            state <= UCL_SAVE;
                        end
                    end else if (do_sel) begin
                        // A plain select write only changes which set is viewed
                        sel_set <= wr_sel;
                    end
                end
                UCL_LOAD: begin
                    // After reset, pick up stored index; unknown falls back to factory
                    if (!booted) begin
                        sel_set  <= boot_set;
                        last_set <= boot_set;
                    end
                    word_idx <= 4'h0;
                    state    <= UCL_COPY;
                end
                UCL_COPY: begin
                    // Camera sees config and restarts its auto loops only after the last word
                    word_idx <= word_idx + 4'h1;
                    if (word_idx == 4'(UCL_SET_WORDS - 1)) begin
                        state        <= UCL_IDLE;
                        booted       <= 1'b1;
                        CFG_VALID    <= 1'b1;
                        AUTO_RESTART <= 1'b1;
                    end
                end
                UCL_SAVE: begin
                    // Set 0 never reaches here, so the factory image cannot be written
                    word_idx <= word_idx + 4'h1;
                    if (word_idx == 4'(UCL_SET_WORDS - 1)) begin
                        state <= UCL_IDLE;
                    end
                end
                default: state <= UCL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Power-up image blanking
    // ------------------------------------------------------------
    // Counter saturates so blanking runs only once per reset; the enable still drops during a reload
    always_ff @(posedge CLK) begin
        if (SRST) begin
            blank_cnt    <= '0;
            IMAGE_ENABLE <= 1'b0;
        end else if (CE) begin
            if (!blank_done) begin
                blank_cnt <= blank_cnt + CW'(1);
            end
            // Dropping with the reload start keeps image off while config is stale
            IMAGE_ENABLE <= blank_done & CFG_VALID & ~load_go;
        end
    end

endmodule

// File: bench/ucl_loader_sva.sv
module ucl_loader_sva
    import ucl_pkg::*;
#(
    parameter int BLANK_CYCLES = UCL_BLANK_CYCLES
) (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        CE,
    input wire logic [15:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [1:0]  NV_LAST_SET_WR,
    input wire logic        NV_LAST_SET_WE,
    input wire logic        IMAGE_ENABLE,
    input wire logic        AUTO_RESTART,
    input wire logic        CFG_VALID,
    input wire logic [31:0] FLASH_CTRL
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    logic [31:0] up_cnt;
    // Enabled cycles since reset release; saturates so a long run cannot wrap below the limit
    always_ff @(posedge CLK) begin
        if (SRST) up_cnt <= 32'h0;
        else if (CE && up_cnt != 32'hFFFF_FFFF) up_cnt <= up_cnt + 32'h1;
    end
    // Decodes of the watched requests
    wire req = CE && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    wire fw_rd = AVS_READ && AVS_ADDRESS == UCL_OFS_FW_VERSION && !AVS_WAITREQUEST;
    wire fl_wr = AVS_WRITE && AVS_ADDRESS == UCL_OFS_FLASH_CTRL && AVS_BYTEENABLE == 4'hF
                 && !AVS_WAITREQUEST;
    sequence answer_s; ##1 !AVS_WAITREQUEST; endsequence
    sequence boot_s; ##[1:40] AUTO_RESTART; endsequence
    bus_answer_a: assert property (req |-> answer_s) else $error("no answer");
    wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
    fw_value_a: assert property (fw_rd |-> AVS_READDATA == UCL_FW_VERSION) else $error("fw value");
    flash_store_a: assert property (fl_wr |=> FLASH_CTRL == $past(AVS_WRITEDATA)) else $error("flash");
    image_blank_a: assert property (IMAGE_ENABLE |-> up_cnt >= BLANK_CYCLES) else $error("early image");
    image_cfg_a: assert property (IMAGE_ENABLE |-> CFG_VALID) else $error("image unconfigured");
    boot_load_a: assert property ($fell(SRST) |-> boot_s) else $error("no boot load");
    restart_pulse_a: assert property (AUTO_RESTART |=> !AUTO_RESTART) else $error("restart level");
    nv_pulse_a: assert property (NV_LAST_SET_WE |=> !NV_LAST_SET_WE) else $error("nv level");
    nv_index_a: assert property (NV_LAST_SET_WE |-> NV_LAST_SET_WR != 2'h3) else $error("nv index");
endmodule
bind ucl_loader ucl_loader_sva #(.BLANK_CYCLES(BLANK_CYCLES)) u_sva (.CLK(CLK), .SRST(SRST),
    .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .NV_LAST_SET_WR(NV_LAST_SET_WR),
    .NV_LAST_SET_WE(NV_LAST_SET_WE), .IMAGE_ENABLE(IMAGE_ENABLE), .AUTO_RESTART(AUTO_RESTART),
    .CFG_VALID(CFG_VALID), .FLASH_CTRL(FLASH_CTRL));

// File: bench/ucl_loader_bench.sv
module ucl_loader_bench
    import ucl_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BLANK = 50;
    logic        clk, srst, ce, rd, wr, reinit, wreq, nv_we, img, arst, cfgv;
    logic [15:0] adr;
    logic [31:0] wdat, rdat, fctl, got, arst_n;
    logic [1:0]  resp, nv_wr, got_resp, nv_seen;
    ucl_env_t    env;
    int          bad_count, n_tests, cyc;
    ucl_loader #(.BLANK_CYCLES(BLANK)) dut (.CLK(clk), .SRST(srst), .CE(ce), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp), .NV_LAST_SET(nv_seen),
        .NV_LAST_SET_WR(nv_wr), .NV_LAST_SET_WE(nv_we), .REINIT(reinit), .ENV_IN(env),
        .IMAGE_ENABLE(img), .AUTO_RESTART(arst), .CFG_VALID(cfgv), .FLASH_CTRL(fctl));
    // ----------------------------------------
    // Clock and monitors
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Pulses are caught here since they stand for one cycle only
    // The captured save index also plays the non-volatile store across a reset
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nv_we === 1'b1) nv_seen <= nv_wr;
        if (arst === 1'b1) arst_n <= arst_n + 32'h1;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the request until waitrequest is sampled low; the timeout ends a hang
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        got = rdat;
        got_resp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, got);
    endtask
    // Save takes 16 copy cycles, so 20 leaves margin
    task automatic save(input logic [1:0] s);
        bus(1'b1, UCL_OFS_SET_CTRL, {26'h0, 2'h1, 2'h0, s});
        repeat (20) @(posedge clk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rd, wr, reinit, srst, ce} = 5'h3;
        adr = 16'h0;
        wdat = 32'h0;
        env = 32'h0019_0028;
        {cyc, bad_count, n_tests, arst_n, nv_seen} = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rdchk("flash reset", UCL_OFS_FLASH_CTRL, UCL_RST_FLASH_CTRL);
        chk("image blanked", 32'h0, {31'h0, img});
        repeat (20) @(posedge clk);
        chk("config loaded", 32'h1, {31'h0, cfgv});
        chk("boot restart", 32'h1, arst_n);
        bus(1'b1, UCL_OFS_FLASH_CTRL, 32'hA5A5_5A5A);
        rdchk("flash ctrl", UCL_OFS_FLASH_CTRL, 32'hA5A5_5A5A);
        chk("flash port", 32'hA5A5_5A5A, fctl);
        bus(1'b1, UCL_OFS_FW_VERSION, 32'h0);
        rdchk("fw version", UCL_OFS_FW_VERSION, UCL_FW_VERSION);
        rdchk("fw date", UCL_OFS_FW_DATE, UCL_FW_DATE);
        rdchk("fw desc", UCL_OFS_FW_DESC, UCL_FW_DESC);
        rdchk("env", UCL_OFS_ENV, 32'h0019_0028);
        bus(1'b0, 16'h0000, 32'h0);
        chk("decode error", 32'h3, {30'h0, got_resp});
        bus(1'b1, UCL_OFS_LIVE_BASE, 32'h1234_5678);
        save(2'h1);
        chk("nv index", 32'h1, {30'h0, nv_seen});
        bus(1'b0, UCL_OFS_SET_STATUS, 32'h0);
        chk("last set", 32'h1, {30'h0, got[1:0]});
        bus(1'b1, UCL_OFS_SET_INDEX, 32'h0);
        bus(1'b1, UCL_OFS_SET_CTRL, 32'h1);
        rdchk("set word", UCL_OFS_SET_DATA, 32'h1234_5678);
        save(2'h0);
        chk("nv factory", 32'h0, {30'h0, nv_seen});
        rdchk("factory word", UCL_OFS_SET_DATA, UCL_RST_WORD);
        save(2'h2);
        bus(1'b1, UCL_OFS_LIVE_BASE, 32'hFFFF_0000);
        @(posedge clk);
        reinit <= 1'b1;
        @(posedge clk);
        reinit <= 1'b0;
        repeat (20) @(posedge clk);
        rdchk("reloaded", UCL_OFS_LIVE_BASE, 32'h1234_5678);
        chk("reinit restart", 32'h2, arst_n);
        repeat (BLANK) @(posedge clk);
        chk("image on", 32'h1, {31'h0, img});
        // Power cycle: the store holds set 2, so boot must restore it over a dirty word
        bus(1'b1, UCL_OFS_LIVE_BASE, 32'hFFFF_0000);
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        chk("image reblanked", 32'h0, {31'h0, img});
        repeat (20) @(posedge clk);
        chk("boot restart again", 32'h3, arst_n);
        rdchk("power restore", UCL_OFS_LIVE_BASE, 32'h1234_5678);
        bus(1'b0, UCL_OFS_SET_STATUS, 32'h0);
        chk("boot index", 32'h2, {30'h0, got[1:0]});
        // Freeze: the blanking count must stall while the enable is low
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        ce <= 1'b1;
        chk("image frozen", 32'h0, {31'h0, img});
        repeat (BLANK) @(posedge clk);
        chk("image again", 32'h1, {31'h0, img});
        give_verdict();
    end
endmodule
